//--- core/msc_pkg.sv
// Function
// - writing 0x0f to operating control enables both sensors, 2g, full resolution
// - operating control resets to 0x00; writing 0x00 stops both sensors
// - output rate control resets to 0x22, meaning 50 Hz for both sensors
// - route value 0x18 sends both data-ready events to the interrupt pin
// - route value 0x02 sends motion events to the interrupt pin
// - pin config 0x04 gives push-pull, active-high, latched interrupt pin
// - direction mask holds one enable per direction; 0x3f enables all six
// - motion threshold is in counts at 16 counts per g
// - motion compares each new reading against the previous one
// - each axis reads as a low and high byte, two's complement, any time
// - motion timer sets how many samples motion must persist before waking
// - a motion wake-up puts the field sensor into operating mode by itself
// - motion timer counts periods of the motion evaluation rate
// - reading the release register clears the latched pin, sources and status bit 0x10
// - pulse mode gives a self-clearing pulse of about 50 us, started or restarted by any routed event
package msc_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SOURCE = 8'h03;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RELEASE = 8'h05;
  localparam logic [7:0] OFS_MASK = 8'h06;
  localparam logic [7:0] OFS_ACCEL_BASE = 8'h0a;
  localparam logic [7:0] OFS_FIELD_BASE = 8'h10;
  localparam logic [7:0] OFS_ROUTE_ONE = 8'h2a;
  localparam logic [7:0] OFS_PIN_CFG = 8'h2c;
  localparam logic [7:0] OFS_DIR_MASK = 8'h2d;
  localparam logic [7:0] OFS_THRESHOLD = 8'h2f;
  localparam logic [7:0] OFS_PERSIST = 8'h30;
  localparam logic [7:0] OFS_RATE_CTL = 8'h38;
  localparam logic [7:0] OFS_OP_CTL = 8'h3a;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_CTL_RST = 8'h00;
  localparam logic [7:0] RATE_CTL_RST = 8'h22;
  localparam logic [7:0] CFG_RST = 8'h00;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int OP_ACCEL_EN = 0;
  localparam int OP_FIELD_EN = 1;
  localparam int OP_FULL_RES = 2;
  localparam int OP_TEMP_OFF = 3;
  localparam int ROUTE_MOTION = 1;
  localparam int ROUTE_FIELD = 3;
  localparam int ROUTE_ACCEL = 4;
  localparam int PIN_PULSE = 0;
  localparam int PIN_OPEN_DRAIN = 1;
  localparam int PIN_ACT_HIGH = 2;
  localparam int SRC_ACCEL = 0;
  localparam int SRC_FIELD = 1;
  localparam int SRC_MOTION = 2;
  localparam int STAT_INT = 4;
  localparam int RATE_FIELD_LSB = 4;
  // ----------------------------------------------------------------
  // timing and scaling
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 125_000_000;
  localparam int RATE_BASE_HZ = 50;
  localparam int RATE_BASE_CODE = 2;
  localparam int RATE_BASE_CYCLES = int'(CLK_HZ / RATE_BASE_HZ);
  localparam int PULSE_US = 50;
  localparam int PULSE_CYCLES = int'((PULSE_US * CLK_HZ) / 1_000_000);
  localparam int COUNTS_PER_G = 16;
  localparam int RAW_PER_G = 16384;
  localparam int THR_SHIFT = $clog2(RAW_PER_G / COUNTS_PER_G);
endpackage : msc_pkg

//--- core/msc_rate_gen.sv
`timescale 1ns/10ps
module msc_rate_gen #(
  parameter int unsigned BASE_CYCLES = msc_pkg::RATE_BASE_CYCLES
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // control
  input  wire logic       en_i,
  input  wire logic [3:0] code_i,
  // sample tick
  output logic            tick_o
);
  // each code step doubles the rate; the base code gives the base rate
  logic [31:0] period;
  logic [31:0] cnt_q;

  assign period = (32'(BASE_CYCLES) << msc_pkg::RATE_BASE_CODE) >> code_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else if (!en_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else if (cnt_q + 32'd1 >= period) begin
      cnt_q  <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 32'd1;
      tick_o <= 1'b0;
    end
  end
endmodule : msc_rate_gen

//--- core/msc_pulse.sv
`timescale 1ns/10ps
module msc_pulse #(
  parameter int unsigned PULSE_CYCLES = msc_pkg::PULSE_CYCLES
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // trigger and pulse
  input  wire logic start_i,
  output logic      active_o
);
  logic [15:0] cnt_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q    <= '0;
      active_o <= 1'b0;
    end else if (start_i) begin
      cnt_q    <= 16'(PULSE_CYCLES - 1);
      active_o <= 1'b1;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 16'd1;
    end else begin
      active_o <= 1'b0;
    end
  end

  a_pulse_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start_i |=> active_o && cnt_q == 16'(PULSE_CYCLES - 1))
    else $error("pulse did not start at full length");
  a_pulse_end: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    active_o && cnt_q == '0 && !start_i |=> !active_o)
    else $error("pulse did not clear itself");
endmodule : msc_pulse

//--- core/msc_core.sv
// Chosen here: strobed register access.
`timescale 1ns/10ps
module msc_core #(
  parameter int unsigned RATE_CYCLES  = msc_pkg::RATE_BASE_CYCLES,
  parameter int unsigned PULSE_CYCLES = msc_pkg::PULSE_CYCLES
) (
  // clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               rst_n_i,
  // register port
  input  wire logic [7:0]         reg_addr_i,
  input  wire logic [7:0]         reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output logic      [7:0]         reg_rdata_o,
  // samples from the sensing front end
  input  wire logic signed [15:0] accel_x_i,
  input  wire logic signed [15:0] accel_y_i,
  input  wire logic signed [15:0] accel_z_i,
  input  wire logic signed [15:0] field_x_i,
  input  wire logic signed [15:0] field_y_i,
  input  wire logic signed [15:0] field_z_i,
  // front end control
  output logic                    accel_run_o,
  output logic                    field_run_o,
  output logic                    full_res_o,
  output logic                    temp_off_o,
  // interrupts
  output logic                    irq_o,
  output logic                    interrupt_pin_one_o,
  output logic                    interrupt_pin_one_oe_o
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0]        op_ctl_q;
  logic [7:0]        rate_ctl_q;
  logic [7:0]        route_q;
  logic [7:0]        pin_cfg_q;
  logic [7:0]        dir_mask_q;
  logic [7:0]        thr_q;
  logic [7:0]        persist_q;
  logic [2:0]        irq_mask_q;
  logic [2:0]        src_q;
  logic signed [15:0] accel_q [3];
  logic signed [15:0] field_q [3];
  logic signed [15:0] accel_in [3];
  logic signed [15:0] field_in [3];
  logic [1:0]        tick;
  logic              wr_en;
  logic              rel_rd;
  logic              accel_ev;
  logic              field_ev;
  logic              motion_ev;
  logic [2:0]        ev_set;
  logic [2:0]        src_clr;

  assign accel_in = '{accel_x_i, accel_y_i, accel_z_i};
  assign field_in = '{field_x_i, field_y_i, field_z_i};
  assign wr_en    = reg_wr_i;
  assign rel_rd   = reg_rd_i && reg_addr_i == msc_pkg::OFS_RELEASE;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      op_ctl_q <= msc_pkg::OP_CTL_RST;
    end else begin
      if (wr_en && reg_addr_i == msc_pkg::OFS_OP_CTL) begin
        op_ctl_q <= reg_wdata_i;
      end
      // the wake-up set wins over a host write in the same cycle
      if (motion_ev) begin
        op_ctl_q[msc_pkg::OP_FIELD_EN] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rate_ctl_q <= msc_pkg::RATE_CTL_RST;
      route_q    <= msc_pkg::CFG_RST;
      pin_cfg_q  <= msc_pkg::CFG_RST;
      dir_mask_q <= msc_pkg::CFG_RST;
      thr_q      <= msc_pkg::CFG_RST;
      persist_q  <= msc_pkg::CFG_RST;
      irq_mask_q <= '0;
    end else if (wr_en) begin
      unique case (reg_addr_i)
        msc_pkg::OFS_RATE_CTL:  rate_ctl_q <= reg_wdata_i;
        msc_pkg::OFS_ROUTE_ONE: route_q    <= reg_wdata_i;
        msc_pkg::OFS_PIN_CFG:   pin_cfg_q  <= reg_wdata_i;
        msc_pkg::OFS_DIR_MASK:  dir_mask_q <= reg_wdata_i & 8'h3f;
        msc_pkg::OFS_THRESHOLD: thr_q      <= reg_wdata_i;
        msc_pkg::OFS_PERSIST:   persist_q  <= reg_wdata_i;
        msc_pkg::OFS_MASK:      irq_mask_q <= reg_wdata_i[2:0];
        default: ;
      endcase
    end
  end

  assign accel_run_o = op_ctl_q[msc_pkg::OP_ACCEL_EN];
  assign field_run_o = op_ctl_q[msc_pkg::OP_FIELD_EN];
  assign full_res_o  = op_ctl_q[msc_pkg::OP_FULL_RES];
  assign temp_off_o  = op_ctl_q[msc_pkg::OP_TEMP_OFF];

  // ----------------------------------------------------------------
  // sample timing, one rate per sensor
  // ----------------------------------------------------------------
  for (genvar s = 0; s < 2; s++) begin : g_rate
    msc_rate_gen #(.BASE_CYCLES(RATE_CYCLES)) u_rate (
      .clk_i  (core_clk_i),
      .rst_n_i(rst_n),
      .en_i   (op_ctl_q[s]),
      .code_i (rate_ctl_q[4*s +: 4]),
      .tick_o (tick[s])
    );
  end

  assign accel_ev = tick[0] && op_ctl_q[msc_pkg::OP_ACCEL_EN];
  assign field_ev = tick[1] && op_ctl_q[msc_pkg::OP_FIELD_EN];

  // ----------------------------------------------------------------
  // output data and per-direction motion hits
  // ----------------------------------------------------------------
  logic [5:0] hit;

  for (genvar a = 0; a < 3; a++) begin : g_axis
    logic signed [16:0] diff;
    logic signed [18:0] thr_raw;
    assign diff    = 17'(accel_in[a]) - 17'(accel_q[a]);
    // 19 bits so that the largest threshold still exceeds any sample difference
    assign thr_raw = {1'b0, thr_q, 10'h000} >>> (10 - msc_pkg::THR_SHIFT);
    assign hit[2*a]   = diff < -thr_raw;
    assign hit[2*a+1] = diff > thr_raw;

    always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
        accel_q[a] <= '0;
        field_q[a] <= '0;
      end else begin
        if (accel_ev) begin
          accel_q[a] <= accel_in[a];
        end
        if (field_ev) begin
          field_q[a] <= field_in[a];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // motion persistence
  // ----------------------------------------------------------------
  logic [7:0] persist_cnt_q;
  logic [7:0] persist_tgt;
  logic       qualify;

  // a timer of zero fires on the first qualifying sample, like a timer of one
  assign persist_tgt = (persist_q == '0) ? 8'h00 : persist_q - 8'h01;
  assign qualify     = |(hit & dir_mask_q[5:0]);
  // the count only advances on evaluation samples, so its unit is one period
  assign motion_ev   = accel_ev && qualify && persist_cnt_q == persist_tgt;

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      persist_cnt_q <= '0;
    end else if (!op_ctl_q[msc_pkg::OP_ACCEL_EN]) begin
      // a stopped sensor starts a fresh persistence run when it is restarted
      persist_cnt_q <= '0;
    end else if (accel_ev) begin
      if (!qualify) begin
        persist_cnt_q <= '0;
      end else if (persist_cnt_q != 8'hff) begin
        persist_cnt_q <= persist_cnt_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt sources
  // ----------------------------------------------------------------
  always_comb begin
    ev_set = '0;
    ev_set[msc_pkg::SRC_ACCEL]  = accel_ev;
    ev_set[msc_pkg::SRC_FIELD]  = field_ev;
    ev_set[msc_pkg::SRC_MOTION] = motion_ev;
    src_clr = '0;
    if (wr_en && reg_addr_i == msc_pkg::OFS_SOURCE) begin
      src_clr = reg_wdata_i[2:0];
    end
    if (rel_rd) begin
      src_clr = '1;
    end
  end

  // a new event in the clearing cycle stays set
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      src_q <= '0;
    end else begin
      src_q <= (src_q & ~src_clr) | ev_set;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(src_q & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------
  // physical interrupt pin
  // ----------------------------------------------------------------
  logic [2:0] src_route;
  logic       routed_new;
  logic       pulse_act;
  logic       asserted;

  assign src_route[msc_pkg::SRC_ACCEL]  = route_q[msc_pkg::ROUTE_ACCEL];
  assign src_route[msc_pkg::SRC_FIELD]  = route_q[msc_pkg::ROUTE_FIELD];
  assign src_route[msc_pkg::SRC_MOTION] = route_q[msc_pkg::ROUTE_MOTION];
  assign routed_new = |(ev_set & src_route);

  msc_pulse #(.PULSE_CYCLES(PULSE_CYCLES)) u_pulse (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n),
    .start_i (routed_new && pin_cfg_q[msc_pkg::PIN_PULSE]),
    .active_o(pulse_act)
  );

  assign asserted = pin_cfg_q[msc_pkg::PIN_PULSE] ? pulse_act
                                                  : |(src_q & src_route);

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_pin_one_o    <= 1'b1;
      interrupt_pin_one_oe_o <= 1'b1;
    end else begin
      interrupt_pin_one_o <= asserted ~^ pin_cfg_q[msc_pkg::PIN_ACT_HIGH];
      // open drain only pulls low; push-pull drives always
      interrupt_pin_one_oe_o <= !pin_cfg_q[msc_pkg::PIN_OPEN_DRAIN] ||
                                !(asserted ~^ pin_cfg_q[msc_pkg::PIN_ACT_HIGH]);
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [7:0] rd_d;

  always_comb begin
    rd_d = '0;
    unique case (reg_addr_i)
      msc_pkg::OFS_OP_CTL:    rd_d = op_ctl_q;
      msc_pkg::OFS_RATE_CTL:  rd_d = rate_ctl_q;
      msc_pkg::OFS_ROUTE_ONE: rd_d = route_q;
      msc_pkg::OFS_PIN_CFG:   rd_d = pin_cfg_q;
      msc_pkg::OFS_DIR_MASK:  rd_d = dir_mask_q;
      msc_pkg::OFS_THRESHOLD: rd_d = thr_q;
      msc_pkg::OFS_PERSIST:   rd_d = persist_q;
      msc_pkg::OFS_MASK:      rd_d = {5'h00, irq_mask_q};
      msc_pkg::OFS_SOURCE:    rd_d = {5'h00, src_q};
      msc_pkg::OFS_RELEASE:   rd_d = {5'h00, src_q};
      msc_pkg::OFS_STATUS: begin
        rd_d = {6'h00, op_ctl_q[1:0]};
        rd_d[msc_pkg::STAT_INT] = |src_q;
      end
      default: ;
    endcase
    for (int a = 0; a < 3; a++) begin
      if (reg_addr_i == 8'(msc_pkg::OFS_ACCEL_BASE + 2 * a)) rd_d = accel_q[a][7:0];
      if (reg_addr_i == 8'(msc_pkg::OFS_ACCEL_BASE + 2 * a + 1)) rd_d = accel_q[a][15:8];
      if (reg_addr_i == 8'(msc_pkg::OFS_FIELD_BASE + 2 * a)) rd_d = field_q[a][7:0];
      if (reg_addr_i == 8'(msc_pkg::OFS_FIELD_BASE + 2 * a + 1)) rd_d = field_q[a][15:8];
    end
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_d : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_op_ctl_write: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    wr_en && reg_addr_i == msc_pkg::OFS_OP_CTL && !motion_ev |=> op_ctl_q == $past(reg_wdata_i))
    else $error("operating control write lost");
  a_rate_write: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    wr_en && reg_addr_i == msc_pkg::OFS_RATE_CTL |=> rate_ctl_q == $past(reg_wdata_i))
    else $error("rate control write lost");
  a_drdy_pin: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (accel_ev && route_q[msc_pkg::ROUTE_ACCEL] && !pin_cfg_q[msc_pkg::PIN_PULSE] && !rel_rd
     && !wr_en) ##1 (!rel_rd && !wr_en) |=>
    interrupt_pin_one_o == pin_cfg_q[msc_pkg::PIN_ACT_HIGH])
    else $error("data ready not shown on pin");
  a_motion_pin: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (motion_ev && route_q[msc_pkg::ROUTE_MOTION] && !pin_cfg_q[msc_pkg::PIN_PULSE] && !rel_rd
     && !wr_en) ##1 (!rel_rd && !wr_en) |=> src_q[msc_pkg::SRC_MOTION] &&
    interrupt_pin_one_o == pin_cfg_q[msc_pkg::PIN_ACT_HIGH])
    else $error("motion not shown on pin");
  a_push_pull: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    !pin_cfg_q[msc_pkg::PIN_OPEN_DRAIN] && !wr_en |=> interrupt_pin_one_oe_o)
    else $error("push-pull pin not driven");
  a_pin_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    src_q == '0 && !pin_cfg_q[msc_pkg::PIN_PULSE] && !wr_en |=>
    interrupt_pin_one_o == !pin_cfg_q[msc_pkg::PIN_ACT_HIGH])
    else $error("idle pin shows wrong level");
  a_persist_up: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    accel_ev && qualify && persist_cnt_q != 8'hff |=> persist_cnt_q == $past(persist_cnt_q) + 8'h01)
    else $error("persistence count did not advance");
  a_persist_clr: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    accel_ev && !(|(hit & dir_mask_q[5:0])) |=> persist_cnt_q == 8'h00)
    else $error("persistence count not cleared");
  a_wake_field: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    motion_ev |=> op_ctl_q[msc_pkg::OP_FIELD_EN] && src_q[msc_pkg::SRC_MOTION])
    else $error("wake-up did not start field sensing");
  a_release_clr: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    rel_rd && ev_set == '0 |=> src_q == '0 ##1 (irq_o == 1'b0))
    else $error("release read did not clear sources");
  a_read_data: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    reg_rd_i && reg_addr_i == msc_pkg::OFS_ACCEL_BASE |=> reg_rdata_o == $past(accel_q[0][7:0]))
    else $error("acceleration low byte read wrong");
endmodule : msc_core

//--- core/msc_top_unused_placeholder.sv
`timescale 1ns/10ps

//--- test/msc_front_model.sv
`timescale 1ns/10ps
module msc_front_model #(
  parameter int unsigned SWING = 40
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // sample setup
  input  wire logic [5:0][15:0] level_i,
  input  wire logic             swing_i,
  // samples to the core
  output logic      [5:0][15:0] smp_o
);
  logic [15:0] cnt_q;
  logic        sign_q;
  // x flips every SWING cycles, so each sample differs from the one before by 10000
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= 16'h0000;
      sign_q <= 1'b0;
    end else if (cnt_q == 16'(SWING - 1)) begin
      cnt_q  <= 16'h0000;
      sign_q <= ~sign_q;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  always_comb begin
    smp_o = level_i;
    if (swing_i) begin
      smp_o[0] = sign_q ? 16'h1388 : 16'hec78;
    end
  end
endmodule : msc_front_model

//--- test/motion_sensor_config_interrupts_bench.sv
`timescale 1ns/10ps
module motion_sensor_config_interrupts_bench;
  localparam int RATE  = 40;
  localparam int PULSE = 10;
  logic             clk = 1'b0;
  logic             rst_n = 1'b0;
  logic [7:0]       addr = 8'h00;
  logic [7:0]       wdata = 8'h00;
  logic             wr = 1'b0;
  logic             rd = 1'b0;
  logic             rd_seen = 1'b0;
  logic [7:0]       rdata;
  logic [7:0]       r;
  logic [5:0][15:0] level = '0;
  logic             swing = 1'b0;
  logic [5:0][15:0] smp;
  logic             a_run, f_run, full_res, temp_off, irq, pin, pin_oe;
  int               failures = 0;
  int               comparisons = 0;
  int               seed = 82569;
  int               n;
  logic [7:0]       exp_q[$];

  always #4 clk = ~clk;

  msc_front_model #(.SWING(RATE)) u_msc_front_model (
    .clk_i(clk), .rst_n_i(rst_n), .level_i(level), .swing_i(swing), .smp_o(smp));

  msc_core #(.RATE_CYCLES(RATE), .PULSE_CYCLES(PULSE)) u_msc_core (
    .core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .accel_x_i(smp[0]), .accel_y_i(smp[1]), .accel_z_i(smp[2]),
    .field_x_i(smp[3]), .field_y_i(smp[4]), .field_z_i(smp[5]),
    .accel_run_o(a_run), .field_run_o(f_run), .full_res_o(full_res),
    .temp_off_o(temp_off), .irq_o(irq), .interrupt_pin_one_o(pin),
    .interrupt_pin_one_oe_o(pin_oe));

  // ------------------------------------------------------------------
  // bus tasks and checking
  // ------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      failures++;
      $display("[FAIL] %0t got %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] want);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(want);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg

  task automatic wait_pin(input int limit);
    n = 0;
    while (pin !== 1'b1 && n < limit) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_pin

  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // read data stand only in the cycle after the strobe, so check exactly there
  always @(posedge clk) begin
    if (rd_seen) begin
      check(rdata, exp_q.pop_front());
    end
    rd_seen <= rd;
  end

  initial begin
    #(8 * 20000);
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  initial begin
    for (int a = 0; a < 6; a++) level[a] <= 16'($random(seed));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check({4'h0, temp_off, full_res, f_run, a_run}, 8'h00);
    check({6'h00, pin_oe, pin}, 8'h03);
    rd_reg(msc_pkg::OFS_OP_CTL, 8'h00);
    rd_reg(msc_pkg::OFS_RATE_CTL, 8'h22);
    rd_reg(8'h7f, 8'h00);
    r = 8'($random(seed));
    wr_reg(msc_pkg::OFS_DIR_MASK, r);
    rd_reg(msc_pkg::OFS_DIR_MASK, r & 8'h3f);
    wr_reg(msc_pkg::OFS_OP_CTL, 8'h0f);
    #1;
    check({4'h0, temp_off, full_res, f_run, a_run}, 8'h0f);
    wr_reg(msc_pkg::OFS_OP_CTL, 8'h00);
    #1;
    check({4'h0, temp_off, full_res, f_run, a_run}, 8'h00);
    $display("test registers done");
    // configuration only while stopped
    wr_reg(msc_pkg::OFS_ROUTE_ONE, 8'h18);
    // the random mask with a zero threshold would raise motion here
    wr_reg(msc_pkg::OFS_DIR_MASK, 8'h00);
    wr_reg(msc_pkg::OFS_PIN_CFG, 8'h04);
    wr_reg(msc_pkg::OFS_MASK, 8'h07);
    wr_reg(msc_pkg::OFS_OP_CTL, 8'h0f);
    wait_pin(3 * RATE);
    check({6'h00, pin_oe, pin}, 8'h03);
    check(8'(irq), 8'h01);
    repeat (RATE + 5) @(posedge clk);
    rd_reg(msc_pkg::OFS_STATUS, 8'h13);
    wr_reg(msc_pkg::OFS_OP_CTL, 8'h00);
    rd_reg(msc_pkg::OFS_RELEASE, 8'h03);
    rd_reg(msc_pkg::OFS_STATUS, 8'h00);
    #1;
    check({6'h00, irq, pin}, 8'h00);
    for (int a = 0; a < 6; a++) begin
      r = (a < 3) ? msc_pkg::OFS_ACCEL_BASE : msc_pkg::OFS_FIELD_BASE;
      r = r + 8'(2 * (a % 3));
      rd_reg(r, level[a][7:0]);
      rd_reg(r + 8'h01, level[a][15:8]);
    end
    $display("test data ready done");
    wr_reg(msc_pkg::OFS_ROUTE_ONE, 8'h10);
    wr_reg(msc_pkg::OFS_PIN_CFG, 8'h05);
    wr_reg(msc_pkg::OFS_OP_CTL, 8'h01);
    wait_pin(3 * RATE);
    n = 0;
    while (pin === 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(8'(n), 8'(PULSE));
    wr_reg(msc_pkg::OFS_OP_CTL, 8'h00);
    rd_reg(msc_pkg::OFS_RELEASE, 8'h01);
    $display("test pulse done");
    wr_reg(msc_pkg::OFS_ROUTE_ONE, 8'h02);
    wr_reg(msc_pkg::OFS_PIN_CFG, 8'h04);
    wr_reg(msc_pkg::OFS_MASK, 8'h00);
    wr_reg(msc_pkg::OFS_DIR_MASK, 8'h3f);
    wr_reg(msc_pkg::OFS_THRESHOLD, 8'h08);
    wr_reg(msc_pkg::OFS_PERSIST, 8'h05);
    swing <= 1'b1;
    wr_reg(msc_pkg::OFS_OP_CTL, 8'h01);
    // five samples at the rate cannot have passed yet
    repeat (150) @(posedge clk);
    #1;
    check(8'(pin), 8'h00);
    wait_pin(5 * RATE);
    check(8'(pin), 8'h01);
    check(8'(irq), 8'h00);
    repeat (RATE + 5) @(posedge clk);
    rd_reg(msc_pkg::OFS_OP_CTL, 8'h03);
    wr_reg(msc_pkg::OFS_OP_CTL, 8'h00);
    rd_reg(msc_pkg::OFS_RELEASE, 8'h07);
    swing <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check(8'(pin), 8'h00);
    $display("test motion done");
    // open drain, active low: released when idle, driven low on an event
    wr_reg(msc_pkg::OFS_PIN_CFG, 8'h02);
    wr_reg(msc_pkg::OFS_ROUTE_ONE, 8'h10);
    repeat (2) @(posedge clk);
    #1;
    check({6'h00, pin_oe, pin}, 8'h01);
    wr_reg(msc_pkg::OFS_OP_CTL, 8'h01);
    n = 0;
    while (pin_oe !== 1'b1 && n < 3 * RATE) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({6'h00, pin_oe, pin}, 8'h02);
    wr_reg(msc_pkg::OFS_OP_CTL, 8'h00);
    wr_reg(msc_pkg::OFS_SOURCE, 8'h01);
    rd_reg(msc_pkg::OFS_SOURCE, 8'h00);
    #1;
    check({6'h00, pin_oe, pin}, 8'h01);
    $display("test open drain done");
    final_report();
  end
endmodule : motion_sensor_config_interrupts_bench
